// ===== logic/ppr_pkg.sv
// Package of constants and carrier types for the peripheral pin router.
package ppr_pkg;

  // ==========================================================================
  // Sizes and code tables
  // ==========================================================================
  localparam int PPR_NUM_PINS = 16;
  localparam int PPR_NUM_INPUTS = 8;
  localparam int PPR_NUM_OUTPUTS = 16;
  localparam int PPR_SEL_W = 6;

  // Pin code: bits 5:3 name the port (A=0, B=1, C=2), bits 2:0 the bit within it.
  localparam logic [PPR_SEL_W-1:0] PPR_PIN_CODE_C7 = 6'h17;
  // Peripheral output code for serial port 1 transmit.
  localparam logic [PPR_SEL_W-1:0] PPR_OUT_CODE_UART_TX = 6'h0C;
  localparam logic [PPR_SEL_W-1:0] PPR_OUT_CODE_BASE = 6'h01;

  // Index of the serial transmit / clock output among the peripheral outputs.
  localparam int PPR_IDX_UART_TX = 11;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [PPR_SEL_W-1:0] PPR_IN_SEL_RST = 6'h00;
  localparam logic [PPR_SEL_W-1:0] PPR_OUT_SEL_RST = 6'h00;
  localparam logic [PPR_NUM_PINS-1:0] PPR_PIN_RST = 16'h0000;
  localparam logic [PPR_NUM_PINS-1:0] PPR_DIR_RST = 16'hFFFF;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [PPR_NUM_OUTPUTS-1:0] data; // Level each peripheral wants on its output.
    logic [PPR_NUM_OUTPUTS-1:0] drive_own; // Peripheral manages the driver itself.
    logic [PPR_NUM_OUTPUTS-1:0] drive_en; // Driver enable when drive_own is set.
  } ppr_periph_out_type;

  typedef struct packed {
    logic [PPR_NUM_PINS-1:0] latch; // Port output latch.
    logic [PPR_NUM_PINS-1:0] dir_in; // Direction control, 1 means input.
    logic [PPR_NUM_PINS-1:0] analog; // Analog select per pin.
  } ppr_port_ctrl_type;

endpackage

// ===== logic/ppr_router.sv
// Peripheral pin router: input and output selection between peripherals and pins.
`timescale 1ns/1ps
// Functional notes
// - Each peripheral input has its own select choosing the feeding pin.
// - Each pin has its own select choosing the peripheral output driving it.
// - Only digital signals are routed; analog stays fixed to its pins.
// - Input and output routing are set independently of each other.
// - Several peripheral inputs may select one pin at the same time.
// - Port data reads return the pin level, low for analog-select pins, regardless of input routing.
// - Analog select set disables the digital input buffer; software clears it first.
// - All input selects share one pin-code table.
// - All output selects share one peripheral-code table.
// - Direction control alone enables the pin driver, except listed peripherals.
// - Serial port synchronous or sync serial I2C peripherals override direction control.
module ppr_router
  import ppr_pkg::*;
(
  input wire logic clock, // Core clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [PPR_NUM_INPUTS*PPR_SEL_W-1:0] in_sel, // Peripheral input selects.
  input wire logic [PPR_NUM_PINS*PPR_SEL_W-1:0] out_sel, // Pin output selects.
  input wire ppr_port_ctrl_type port_ctrl, // Port latch, direction, analog select.
  input wire ppr_periph_out_type periph_out, // Peripheral outputs.
  input wire logic [PPR_NUM_PINS-1:0] pin_in, // Level seen at each pin.
  output logic [PPR_NUM_INPUTS-1:0] periph_in, // Routed peripheral inputs.
  output logic [PPR_NUM_PINS-1:0] pin_out, // Pin output levels.
  output logic [PPR_NUM_PINS-1:0] pin_oe, // Pin driver enables, high drives.
  output logic [PPR_NUM_PINS-1:0] port_read // Port data as read by software.
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Digital input buffers
  // ==========================================================================
  // A pin with analog select set presents a constant low to every digital reader,
  // so analog levels never reach peripheral logic.
  logic [PPR_NUM_PINS-1:0] dig_in;

  always_comb begin
    dig_in = pin_in & ~port_ctrl.analog;
  end

  // ==========================================================================
  // Input routing
  // ==========================================================================
  logic [PPR_NUM_INPUTS-1:0] periph_in_nxt;

  // Decoding is stateless per input, so any number may share one pin.
  for (genvar gi = 0; gi < PPR_NUM_INPUTS; gi++) begin : g_in
    logic [PPR_SEL_W-1:0] code;
    logic [4:0] idx;
    assign code = in_sel[gi*PPR_SEL_W +: PPR_SEL_W];
    assign idx = {code[4:3], code[2:0]};
    // Codes beyond the implemented pins read low.
    assign periph_in_nxt[gi] = (code[5] == 1'b0 && idx < 5'(PPR_NUM_PINS)) ?
                               dig_in[idx[3:0]] : 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      periph_in <= '0;
    end else if (!rst_n_r) begin
      periph_in <= '0;
    end else begin
      periph_in <= periph_in_nxt;
    end
  end

  // Port read ignores input routing entirely.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_read <= PPR_PIN_RST;
    end else if (!rst_n_r) begin
      port_read <= PPR_PIN_RST;
    end else begin
      port_read <= dig_in;
    end
  end

  // ==========================================================================
  // Output routing
  // ==========================================================================
  logic [PPR_NUM_PINS-1:0] pin_out_nxt;
  logic [PPR_NUM_PINS-1:0] pin_oe_nxt;

  for (genvar gp = 0; gp < PPR_NUM_PINS; gp++) begin : g_out
    logic [PPR_SEL_W-1:0] code;
    logic [PPR_SEL_W-1:0] pidx;
    logic hit;
    assign code = out_sel[gp*PPR_SEL_W +: PPR_SEL_W];
    assign pidx = code - PPR_OUT_CODE_BASE;
    assign hit = (code >= PPR_OUT_CODE_BASE) &&
                 (pidx < PPR_SEL_W'(PPR_NUM_OUTPUTS));
    always_comb begin
      if (hit) begin
        pin_out_nxt[gp] = periph_out.data[pidx[3:0]];
        if (periph_out.drive_own[pidx[3:0]]) begin
          pin_oe_nxt[gp] = periph_out.drive_en[pidx[3:0]];
        end else begin
          pin_oe_nxt[gp] = ~port_ctrl.dir_in[gp];
        end
      end else begin
        pin_out_nxt[gp] = port_ctrl.latch[gp];
        pin_oe_nxt[gp] = ~port_ctrl.dir_in[gp];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= PPR_PIN_RST;
      pin_oe <= ~PPR_DIR_RST;
    end else if (!rst_n_r) begin
      pin_out <= PPR_PIN_RST;
      pin_oe <= ~PPR_DIR_RST;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Input 4 selects pin 9, the pin whose analog select the bench raises.
  property p_analog_blocks;
    @(posedge clock) disable iff (!rst_n_r)
    (port_ctrl.analog[9] && in_sel[5*PPR_SEL_W-1:4*PPR_SEL_W] == 6'h09) |=> !periph_in[4];
  endproperty
  a_analog_blocks: assert property (p_analog_blocks) else $error("analog pin reached input");

  property p_in_route;
    @(posedge clock) disable iff (!rst_n_r)
    (in_sel[PPR_SEL_W-1:0] == 6'h05 && !port_ctrl.analog[5]) |=> periph_in[0] == $past(pin_in[5]);
  endproperty
  a_in_route: assert property (p_in_route) else $error("input route wrong");

  property p_shared_pin;
    @(posedge clock) disable iff (!rst_n_r)
    (in_sel[PPR_SEL_W-1:0] == in_sel[2*PPR_SEL_W-1:PPR_SEL_W]) |=> periph_in[0] == periph_in[1];
  endproperty
  a_shared_pin: assert property (p_shared_pin) else $error("shared pin differs");

  property p_port_read;
    @(posedge clock) disable iff (!rst_n_r)
    !port_ctrl.analog[3] |=> port_read[3] == $past(pin_in[3]);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read wrong");

  property p_latch_default;
    @(posedge clock) disable iff (!rst_n_r)
    (out_sel[PPR_SEL_W-1:0] == 6'h00) |=> pin_out[0] == $past(port_ctrl.latch[0]);
  endproperty
  a_latch_default: assert property (p_latch_default) else $error("unrouted pin not latch");

  // Pin 6 is the pin that carries the serial transmit output in use.
  property p_out_route;
    @(posedge clock) disable iff (!rst_n_r)
    (out_sel[7*PPR_SEL_W-1:6*PPR_SEL_W] == PPR_OUT_CODE_UART_TX) |=> pin_out[6] == $past(periph_out.data[PPR_IDX_UART_TX]);
  endproperty
  a_out_route: assert property (p_out_route) else $error("output route wrong");

  property p_dir_ctrl;
    @(posedge clock) disable iff (!rst_n_r)
    (out_sel[PPR_SEL_W-1:0] == 6'h00) |=> pin_oe[0] == !$past(port_ctrl.dir_in[0]);
  endproperty
  a_dir_ctrl: assert property (p_dir_ctrl) else $error("direction ignored");

  property p_override;
    @(posedge clock) disable iff (!rst_n_r)
    (out_sel[7*PPR_SEL_W-1:6*PPR_SEL_W] == PPR_OUT_CODE_UART_TX && periph_out.drive_own[PPR_IDX_UART_TX])
      |=> pin_oe[6] == $past(periph_out.drive_en[PPR_IDX_UART_TX]);
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  // Port C codes name pins that this block does not implement, so they read low.
  property p_code_beyond;
    @(posedge clock) disable iff (!rst_n_r)
    (in_sel[PPR_SEL_W-1:0] == PPR_PIN_CODE_C7) |=> !periph_in[0];
  endproperty
  a_code_beyond: assert property (p_code_beyond) else $error("unimplemented pin code read high");

  property p_analog_port;
    @(posedge clock) disable iff (!rst_n_r)
    port_ctrl.analog[9] |=> !port_read[9];
  endproperty
  a_analog_port: assert property (p_analog_port) else $error("analog pin read high");

  property p_code_table;
    @(posedge clock) disable iff (!rst_n_r)
    (out_sel[2*PPR_SEL_W-1:PPR_SEL_W] == 6'h02) |=> pin_out[1] == $past(periph_out.data[1]);
  endproperty
  a_code_table: assert property (p_code_table) else $error("output code table wrong");

  // Holding the sync reset forces the drivers off whatever the inputs ask.
  property p_reset_quiet;
    @(posedge clock)
    !rst_n_r |=> pin_oe == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("driver on in reset");

endmodule // ppr_router

// ===== verification/ppr_pad_model.sv
// Pad model standing between the router and the outside world.
`timescale 1ns/1ps
module ppr_pad_model
  import ppr_pkg::*;
(
  pin_out, // Router drive level.
  pin_oe, // Router drive enable.
  ext_level, // Outside source level.
  pin_level // Level seen at the pad.
);
  input wire logic [PPR_NUM_PINS-1:0] pin_out;
  input wire logic [PPR_NUM_PINS-1:0] pin_oe;
  input wire logic [PPR_NUM_PINS-1:0] ext_level;
  output logic [PPR_NUM_PINS-1:0] pin_level;
  // A driven pad shows the router, so port reads see the real pad level.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // ppr_pad_model

// ===== verification/testbench.sv
// Self-checking bench for the peripheral pin router.
`timescale 1ns/1ps
module testbench;
  import ppr_pkg::*;
  logic clock;
  logic arst_n;
  logic [PPR_NUM_INPUTS*PPR_SEL_W-1:0] in_sel;
  logic [PPR_NUM_PINS*PPR_SEL_W-1:0] out_sel;
  ppr_port_ctrl_type port_ctrl;
  ppr_periph_out_type periph_out;
  logic [PPR_NUM_PINS-1:0] ext_level, pin_in, pin_out, pin_oe, port_read;
  logic [PPR_NUM_INPUTS-1:0] periph_in;
  int err_total, check_count, cycles;
  ppr_router dut (.clock(clock), .arst_n(arst_n), .in_sel(in_sel), .out_sel(out_sel),
    .port_ctrl(port_ctrl), .periph_out(periph_out), .pin_in(pin_in),
    .periph_in(periph_in), .pin_out(pin_out), .pin_oe(pin_oe), .port_read(port_read));
  ppr_pad_model pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_level(pin_in));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Outputs are registered, so three edges cover sampling plus latency.
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    err_total = 0;
    check_count = 0;
    cycles = 0;
    arst_n = 1'b0;
    in_sel = '0;
    out_sel = '0;
    ext_level = 16'h0000;
    port_ctrl = '{latch: 16'h0000, dir_in: PPR_DIR_RST, analog: 16'h0000};
    periph_out = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk({periph_in, pin_oe[7:0]}, 16'h0000);
    $display("reset test done");
    // Inputs on distinct pins, then all inputs sharing pin 5.
    @(posedge clock);
    ext_level <= 16'h2202;
    for (int k = 0; k < PPR_NUM_INPUTS; k++) in_sel[k*6 +: 6] <= 6'(2 * k + 1);
    settle();
    chk({8'h00, periph_in}, 16'h0051);
    chk(port_read, 16'h2202);
    chk(pin_out, 16'h0000);
    @(posedge clock);
    port_ctrl.analog <= 16'h0200;
    settle();
    chk({8'h00, periph_in}, 16'h0041);
    chk(port_read, 16'h2002);
    @(posedge clock);
    ext_level <= 16'hFFFF;
    in_sel[5:0] <= PPR_PIN_CODE_C7;
    settle();
    chk({8'h00, periph_in}, 16'h00EE);
    chk(port_read, 16'hFDFF);
    @(posedge clock);
    ext_level <= 16'h0020;
    for (int k = 0; k < PPR_NUM_INPUTS; k++) in_sel[k*6 +: 6] <= 6'h05;
    settle();
    chk({8'h00, periph_in}, 16'h00FF);
    $display("input routing test done");
    // Every pin names its own peripheral, then even pins name none.
    @(posedge clock);
    port_ctrl <= '{latch: 16'h0F0F, dir_in: 16'h0000, analog: 16'h0000};
    periph_out.data <= 16'hC35A;
    for (int p = 0; p < PPR_NUM_PINS; p++) out_sel[p*6 +: 6] <= PPR_OUT_CODE_BASE + 6'(p);
    settle();
    chk(pin_out, 16'hC35A);
    chk(pin_oe, 16'hFFFF);
    chk({8'h00, periph_in}, 16'h0000);
    @(posedge clock);
    for (int p = 0; p < PPR_NUM_PINS; p += 2) out_sel[p*6 +: 6] <= 6'h00;
    settle();
    chk(pin_out, 16'h870F);
    @(posedge clock);
    port_ctrl.dir_in <= 16'hFFFF;
    out_sel[36 +: 6] <= PPR_OUT_CODE_UART_TX;
    periph_out <= '{data: 16'h0800, drive_own: 16'h0800, drive_en: 16'h0800};
    settle();
    chk(pin_oe, 16'h0840);
    chk(pin_out & 16'h0840, 16'h0840);
    @(posedge clock);
    periph_out.drive_en <= 16'h0000;
    settle();
    chk(pin_oe, 16'h0000);
    $display("output routing test done");
    end_of_test();
  end
endmodule // testbench
